// file: logic/tx_power_regs.svh
// Register offsets, field positions, reset values and timing counts of the transmit control block
`ifndef TX_POWER_REGS_SVH
`define TX_POWER_REGS_SVH

`define OFS_LEVEL_BASE  8'h00
`define OFS_RAMP_CFG    8'h08
`define OFS_MODE        8'h09
`define OFS_EIGHTH_LO   8'h0A
`define OFS_EIGHTH_HI   8'h0B
`define OFS_BASE_B0     8'h0C
`define OFS_BASE_B1     8'h0D
`define OFS_BASE_B2     8'h0E
`define OFS_BASE_B3     8'h0F
`define OFS_REF_BAND    8'h10
`define OFS_TRIM_LO     8'h11
`define OFS_TRIM_HI     8'h12
`define OFS_RASTER      8'h13
`define OFS_CHAN        8'h14
`define OFS_BANDF_BASE  8'h15
`define OFS_SETUP       8'h19
`define OFS_STATUS      8'h1A

`define RAMP_ON_BIT     0
`define RAMP_TOP_LSB    1
`define RAMP_HOLD_LSB   4
`define LOAD_TUNE_LSB   6
`define REF_HALVE_BIT   0
`define BAND_LSB        1
`define LOW_OSC_BIT     2
`define HIGH_OSC_BIT    1
`define BUSY_BIT        0

`define RAMP_CFG_RST    8'h0E
`define MODE_RST        2'h0
`define BANDF_RST       8'h01
`define EIGHTH_DIV_RST  16'h0064

`define LVL_OFF         7'h00
`define LVL_MIN         7'h5A

`define FXO_HZ_DFLT     32'h018CBA80
`define BASE_FRAC_BITS  18
`define RASTER_SHIFT    15
`define THR_VLOW        32'h099CF4E2
`define THR_LOW         32'h1339E9C4
`define THR_MID         32'h19A28D06
`define THR_HIGH        32'h33451A0B

`endif

// file: logic/tx_power_pkg.sv
// Types shared by the transmit control block
package tx_power_pkg;

  typedef enum logic [1:0] {
    MODE_FM  = 2'h0,
    MODE_ASK = 2'h1,
    MODE_OOK = 2'h2
  } tx_mode_e;

  typedef enum logic [1:0] {
    R_IDLE = 2'h0,
    R_UP   = 2'h1,
    R_TOP  = 2'h3,
    R_DOWN = 2'h2
  } ramp_state_e;

  typedef enum logic [1:0] {
    C_IDLE  = 2'h0,
    C_DIV   = 2'h1,
    C_SCALE = 2'h3
  } calc_state_e;

endpackage : tx_power_pkg

// file: logic/bit_tick_gen.sv
// Divider giving one enable pulse per eighth of a bit period
`timescale 1ns/10ps
module bit_tick_gen #(
  parameter int W = 16
) (
  input  wire logic         clk_sys_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] reload_i,
  output logic              tick_o
);
  logic [W-1:0] cnt_r;

  // Period is reload_i + 1 cycles; a new reload takes effect at the next wrap
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cnt_r  <= '0;
      tick_o <= 1'b0;
    end else if (cnt_r == '0) begin
      cnt_r  <= reload_i;
      tick_o <= 1'b1;
    end else begin
      cnt_r  <= cnt_r - 1'b1;
      tick_o <= 1'b0;
    end
  end
endmodule : bit_tick_gen

// file: logic/freq_div.sv
// Sequential restoring divider, one quotient bit per cycle
`timescale 1ns/10ps
module freq_div #(
  parameter int NW = 58,
  parameter int DW = 9
) (
  input  wire logic          clk_sys_i,
  input  wire logic          sys_rst_i,
  input  wire logic          start_i,
  input  wire logic [NW-1:0] num_i,
  input  wire logic [DW-1:0] den_i,
  output logic               done_o,
  output logic [NW-1:0]      quot_o
);
  localparam int CW = $clog2(NW + 1);

  logic [DW:0]   rem_r;
  logic [DW-1:0] den_r;
  logic [CW-1:0] cnt_r;
  logic [DW:0]   trial;
  logic          fits;

  assign trial = {rem_r[DW-1:0], quot_o[NW-1]};
  assign fits  = (trial >= {1'b0, den_r});

  // Zero divisor gives all ones; software must not program a zero band factor
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rem_r  <= '0;
      den_r  <= '0;
      cnt_r  <= '0;
      quot_o <= '0;
      done_o <= 1'b0;
    end else if (start_i) begin
      rem_r  <= '0;
      den_r  <= den_i;
      cnt_r  <= CW'(NW);
      quot_o <= num_i;
      done_o <= 1'b0;
    end else if (cnt_r != '0) begin
      rem_r  <= fits ? (trial - {1'b0, den_r}) : trial;
      quot_o <= {quot_o[NW-2:0], fits};
      cnt_r  <= cnt_r - 1'b1;
      done_o <= (cnt_r == CW'(1));
    end else begin
      done_o <= 1'b0;
    end
  end
endmodule : freq_div

// file: logic/tx_power_ramp_and_channel_word.sv
// Amplifier level ramp, ASK/OOK shaping and synthesizer channel word with oscillator pick
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "tx_power_regs.svh"

// Contract
// - Code zero turns amplifier off, high impedance
// - Eight seven-bit level table entries
// - Ramp starts at entry zero, climbs to top
// - Each ramp step lasts hold+1 eighth bits
// - ASK counter up on one, down on zero
// - ASK counter steps each eighth bit, ignores hold
// - ASK counter saturates at top and zero
// - ASK counter selects the driving table entry
// - OOK switches between entry zero and top
// - Two-bit load tune picks amplifier capacitance
// - Centre is base plus trim plus channel raster
// - Eight-bit channel index, 256 channels
// - Base from 26-bit word over band factor
// - Reference divider one or two by ref_halve
// - Trim is signed 12-bit times crystal over 2^18
// - Below threshold picks low oscillator, bit two
// - Above threshold picks high oscillator, reset default
module tx_power_ramp_and_channel_word #(
  parameter logic [31:0] FXO_HZ = `FXO_HZ_DFLT,
  parameter int          TW     = 16
) (
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        tx_active_i,
  input  wire logic        tx_bit_i,
  output logic      [6:0]  amp_level_o,
  output logic             amp_hiz_o,
  output logic      [1:0]  amp_load_tune_o,
  output logic      [31:0] centre_hz_o,
  output logic             low_osc_pick_o,
  output logic             high_osc_pick_o
);
  localparam int NW = 58;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [6:0]  amp_level_entry [8];
  logic [7:0]  ramp_cfg_r;
  logic [1:0]  mode_r;
  logic [15:0] eighth_div_r;
  logic [25:0] synth_base_word_r;
  logic [2:0]  ref_band_r;
  logic [11:0] freq_trim_r;
  logic [7:0]  channel_raster_r;
  logic [7:0]  channel_index_r;
  logic [7:0]  band_factor_r [4];
  logic        calc_pend_r;

  logic        ramp_on;
  logic [2:0]  ramp_top_index;
  logic [1:0]  ramp_hold_time;
  logic        ref_halve;
  logic [1:0]  band_sel;
  tx_power_pkg::tx_mode_e mode;

  assign ramp_on        = ramp_cfg_r[`RAMP_ON_BIT];
  assign ramp_top_index = ramp_cfg_r[`RAMP_TOP_LSB +: 3];
  assign ramp_hold_time = ramp_cfg_r[`RAMP_HOLD_LSB +: 2];
  assign ref_halve      = ref_band_r[`REF_HALVE_BIT];
  assign band_sel       = ref_band_r[`BAND_LSB +: 2];
  assign mode           = tx_power_pkg::tx_mode_e'(mode_r);

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_level
      always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
          amp_level_entry[g] <= `LVL_OFF;
        end else if (reg_wr_i && reg_addr_i == (`OFS_LEVEL_BASE + 8'(g))) begin
          amp_level_entry[g] <= reg_wdata_i[6:0];
        end
      end
    end
    for (g = 0; g < 4; g++) begin : g_bandf
      always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
          band_factor_r[g] <= `BANDF_RST;
        end else if (reg_wr_i && reg_addr_i == (`OFS_BANDF_BASE + 8'(g))) begin
          band_factor_r[g] <= reg_wdata_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ramp_cfg_r        <= `RAMP_CFG_RST;
      mode_r            <= `MODE_RST;
      eighth_div_r      <= `EIGHTH_DIV_RST;
      synth_base_word_r <= '0;
      ref_band_r        <= '0;
      freq_trim_r       <= '0;
      channel_raster_r  <= '0;
      channel_index_r   <= '0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `OFS_RAMP_CFG:  ramp_cfg_r               <= reg_wdata_i;
        `OFS_MODE:      mode_r                   <= reg_wdata_i[1:0];
        `OFS_EIGHTH_LO: eighth_div_r[7:0]        <= reg_wdata_i;
        `OFS_EIGHTH_HI: eighth_div_r[15:8]       <= reg_wdata_i;
        `OFS_BASE_B0:   synth_base_word_r[7:0]   <= reg_wdata_i;
        `OFS_BASE_B1:   synth_base_word_r[15:8]  <= reg_wdata_i;
        `OFS_BASE_B2:   synth_base_word_r[23:16] <= reg_wdata_i;
        `OFS_BASE_B3:   synth_base_word_r[25:24] <= reg_wdata_i[1:0];
        `OFS_REF_BAND:  ref_band_r               <= reg_wdata_i[2:0];
        `OFS_TRIM_LO:   freq_trim_r[7:0]         <= reg_wdata_i;
        `OFS_TRIM_HI:   freq_trim_r[11:8]        <= reg_wdata_i[3:0];
        `OFS_RASTER:    channel_raster_r         <= reg_wdata_i;
        `OFS_CHAN:      channel_index_r          <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Level ramp and ASK/OOK shaping
  tx_power_pkg::ramp_state_e state_r;
  logic [2:0] idx_r;
  logic [1:0] hold_r;
  logic       tick;
  logic       step;
  logic [6:0] cur_code;
  logic [6:0] out_code;

  bit_tick_gen #(.W(TW)) u_tick (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .reload_i  (eighth_div_r),
    .tick_o    (tick)
  );

  assign step = tick && (hold_r == ramp_hold_time);

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_r <= tx_power_pkg::R_IDLE;
      idx_r   <= '0;
      hold_r  <= '0;
    end else begin
      case (state_r)
        tx_power_pkg::R_IDLE: begin
          hold_r <= '0;
          if (!tx_active_i) begin
            idx_r <= '0;
          end else if (mode == tx_power_pkg::MODE_ASK) begin
            idx_r   <= '0;
            state_r <= tx_power_pkg::R_TOP;
          end else if (mode == tx_power_pkg::MODE_OOK) begin
            idx_r   <= tx_bit_i ? ramp_top_index : 3'h0;
            state_r <= tx_power_pkg::R_TOP;
          end else if (ramp_on) begin
            idx_r   <= '0;
            state_r <= tx_power_pkg::R_UP;
          end else begin
            idx_r   <= ramp_top_index;
            state_r <= tx_power_pkg::R_TOP;
          end
        end
        tx_power_pkg::R_UP: begin
          if (!tx_active_i) begin
            hold_r  <= '0;
            state_r <= tx_power_pkg::R_DOWN;
          end else if (step) begin
            hold_r <= '0;
            if (idx_r >= ramp_top_index) begin
              state_r <= tx_power_pkg::R_TOP;
            end else begin
              idx_r <= idx_r + 3'h1;
              if (idx_r + 3'h1 == ramp_top_index) begin
                state_r <= tx_power_pkg::R_TOP;
              end
            end
          end else if (tick) begin
            hold_r <= hold_r + 2'h1;
          end
        end
        tx_power_pkg::R_TOP: begin
          hold_r <= '0;
          if (!tx_active_i) begin
            if (mode == tx_power_pkg::MODE_FM && ramp_on && idx_r != 3'h0) begin
              state_r <= tx_power_pkg::R_DOWN;
            end else begin
              idx_r   <= '0;
              state_r <= tx_power_pkg::R_IDLE;
            end
          end else if (mode == tx_power_pkg::MODE_ASK) begin
            // Hold width is not used here: one count per eighth bit
            if (tick) begin
              if (tx_bit_i) begin
                idx_r <= (idx_r >= ramp_top_index) ? ramp_top_index : idx_r + 3'h1;
              end else begin
                idx_r <= (idx_r == 3'h0) ? 3'h0 : idx_r - 3'h1;
              end
            end
          end else if (mode == tx_power_pkg::MODE_OOK) begin
            idx_r <= tx_bit_i ? ramp_top_index : 3'h0;
          end
        end
        tx_power_pkg::R_DOWN: begin
          if (step) begin
            hold_r <= '0;
            if (idx_r == 3'h0) begin
              state_r <= tx_power_pkg::R_IDLE;
            end else begin
              idx_r <= idx_r - 3'h1;
            end
          end else if (tick) begin
            hold_r <= hold_r + 2'h1;
          end
        end
        default: state_r <= tx_power_pkg::R_IDLE;
      endcase
    end
  end

  // Reserved codes above the minimum level are clamped to it
  assign cur_code = amp_level_entry[idx_r];
  assign out_code = (state_r == tx_power_pkg::R_IDLE) ? `LVL_OFF :
                    ((cur_code > `LVL_MIN) ? `LVL_MIN : cur_code);

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      amp_level_o     <= `LVL_OFF;
      amp_hiz_o       <= 1'b1;
      amp_load_tune_o <= '0;
    end else begin
      amp_level_o     <= out_code;
      amp_hiz_o       <= (out_code == `LVL_OFF);
      amp_load_tune_o <= ramp_cfg_r[`LOAD_TUNE_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel centre and oscillator pick
  tx_power_pkg::calc_state_e calc_r;
  logic              div_start;
  logic              div_done;
  logic [NW-1:0]     div_quot;
  logic [8:0]        div_den;
  logic signed [63:0] base_hz;
  logic signed [63:0] off_hz;
  logic signed [63:0] chan_hz;
  logic signed [63:0] fc_sum;
  logic [31:0]       thr;
  logic              freq_wr;

  assign freq_wr = reg_wr_i && ((reg_addr_i >= `OFS_BASE_B0 && reg_addr_i <= `OFS_CHAN) ||
                   (reg_addr_i >= `OFS_BANDF_BASE && reg_addr_i < `OFS_SETUP));
  assign div_start = (calc_r == tx_power_pkg::C_IDLE) && calc_pend_r;
  assign div_den   = ref_halve ? {band_factor_r[band_sel], 1'b0}
                               : {1'b0, band_factor_r[band_sel]};

  freq_div #(.NW(NW), .DW(9)) u_div (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (div_start),
    .num_i     (NW'(synth_base_word_r) * NW'(FXO_HZ)),
    .den_i     (div_den),
    .done_o    (div_done),
    .quot_o    (div_quot)
  );

  assign base_hz = $signed({24'h0, div_quot[NW-1:`BASE_FRAC_BITS]});
  assign off_hz  = ($signed({{52{freq_trim_r[11]}}, freq_trim_r}) *
                    $signed({32'h0, FXO_HZ})) >>> `BASE_FRAC_BITS;
  assign chan_hz = $signed((64'(channel_raster_r) * 64'(channel_index_r) * 64'(FXO_HZ))
                    >> `RASTER_SHIFT);
  assign fc_sum  = base_hz + off_hz + chan_hz;

  always_comb begin
    case (band_sel)
      2'h0:    thr = `THR_VLOW;
      2'h1:    thr = `THR_LOW;
      2'h2:    thr = `THR_MID;
      default: thr = `THR_HIGH;
    endcase
  end

  // A write during a calculation re-arms it; the write wins over the launch
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      calc_pend_r <= 1'b1;
    end else if (freq_wr) begin
      calc_pend_r <= 1'b1;
    end else if (div_start) begin
      calc_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      calc_r          <= tx_power_pkg::C_IDLE;
      centre_hz_o     <= '0;
      low_osc_pick_o  <= 1'b0;
      high_osc_pick_o <= 1'b1;
    end else begin
      case (calc_r)
        tx_power_pkg::C_IDLE:  if (div_start) calc_r <= tx_power_pkg::C_DIV;
        tx_power_pkg::C_DIV:   if (div_done) calc_r <= tx_power_pkg::C_SCALE;
        tx_power_pkg::C_SCALE: begin
          centre_hz_o     <= fc_sum[31:0];
          low_osc_pick_o  <= (fc_sum < $signed({32'h0, thr}));
          high_osc_pick_o <= !(fc_sum < $signed({32'h0, thr}));
          calc_r          <= tx_power_pkg::C_IDLE;
        end
        default: calc_r <= tx_power_pkg::C_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr_i)
      `OFS_RAMP_CFG:  rd_mux = ramp_cfg_r;
      `OFS_MODE:      rd_mux = {6'h00, mode_r};
      `OFS_EIGHTH_LO: rd_mux = eighth_div_r[7:0];
      `OFS_EIGHTH_HI: rd_mux = eighth_div_r[15:8];
      `OFS_BASE_B0:   rd_mux = synth_base_word_r[7:0];
      `OFS_BASE_B1:   rd_mux = synth_base_word_r[15:8];
      `OFS_BASE_B2:   rd_mux = synth_base_word_r[23:16];
      `OFS_BASE_B3:   rd_mux = {6'h00, synth_base_word_r[25:24]};
      `OFS_REF_BAND:  rd_mux = {5'h00, ref_band_r};
      `OFS_TRIM_LO:   rd_mux = freq_trim_r[7:0];
      `OFS_TRIM_HI:   rd_mux = {4'h0, freq_trim_r[11:8]};
      `OFS_RASTER:    rd_mux = channel_raster_r;
      `OFS_CHAN:      rd_mux = channel_index_r;
      `OFS_SETUP:     rd_mux = {5'h00, low_osc_pick_o, high_osc_pick_o,
                                calc_r != tx_power_pkg::C_IDLE || calc_pend_r};
      `OFS_STATUS:    rd_mux = {3'h0, idx_r, state_r};
      default: begin
        if (reg_addr_i < `OFS_RAMP_CFG) begin
          rd_mux = {1'b0, amp_level_entry[reg_addr_i[2:0]]};
        end else if (reg_addr_i >= `OFS_BANDF_BASE && reg_addr_i < `OFS_SETUP) begin
          rd_mux = band_factor_r[2'(reg_addr_i - `OFS_BANDF_BASE)];
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  a_off_is_hiz: assert property (amp_hiz_o == (amp_level_o == `LVL_OFF))
    else $error("hiz flag disagrees with level code");
  a_no_reserved: assert property (amp_level_o <= `LVL_MIN)
    else $error("reserved level code driven");
  a_ramp_start_zero: assert property ((state_r == tx_power_pkg::R_IDLE && tx_active_i &&
      mode == tx_power_pkg::MODE_FM && ramp_on) |=> (idx_r == 3'h0 && state_r == tx_power_pkg::R_UP))
    else $error("ramp did not start at entry zero");
  a_step_hold: assert property ((state_r == tx_power_pkg::R_UP && tx_active_i &&
      idx_r < ramp_top_index) ##1 $changed(idx_r) |-> $past(hold_r) == $past(ramp_hold_time))
    else $error("ramp stepped before hold expired");
  a_ask_count: assert property ((state_r == tx_power_pkg::R_TOP && mode == tx_power_pkg::MODE_ASK &&
      tx_active_i && tick && idx_r < ramp_top_index && tx_bit_i) |=> idx_r == $past(idx_r) + 3'h1)
    else $error("ASK counter did not count up");
  a_ask_no_tick: assert property ((state_r == tx_power_pkg::R_TOP && mode == tx_power_pkg::MODE_ASK &&
      tx_active_i && !tick) |=> $stable(idx_r))
    else $error("ASK counter moved without tick");
  a_ask_floor: assert property ((state_r == tx_power_pkg::R_TOP && mode == tx_power_pkg::MODE_ASK &&
      tx_active_i && tick && !tx_bit_i && idx_r == 3'h0) |=> idx_r == 3'h0)
    else $error("ASK counter wrapped below zero");
  a_table_drive: assert property ((state_r != tx_power_pkg::R_IDLE && cur_code <= `LVL_MIN)
      |=> amp_level_o == $past(cur_code))
    else $error("level output not from selected entry");
  a_ook_two_level: assert property ((state_r == tx_power_pkg::R_TOP && mode == tx_power_pkg::MODE_OOK &&
      tx_active_i) |=> idx_r == ($past(tx_bit_i) ? $past(ramp_top_index) : 3'h0))
    else $error("OOK index not entry zero or top");
  a_ramp_down: assert property ((state_r == tx_power_pkg::R_DOWN && step && idx_r != 3'h0)
      |=> idx_r == $past(idx_r) - 3'h1)
    else $error("ramp down step wrong");
  a_osc_pick: assert property ((calc_r == tx_power_pkg::C_SCALE) |=>
      (low_osc_pick_o != high_osc_pick_o) && low_osc_pick_o == $past(fc_sum < $signed({32'h0, thr})))
    else $error("oscillator pick disagrees with threshold");

  c_ramp_top: cover property (state_r == tx_power_pkg::R_UP ##1 state_r == tx_power_pkg::R_TOP);
  c_ramp_done: cover property (state_r == tx_power_pkg::R_DOWN ##1 state_r == tx_power_pkg::R_IDLE);
  c_ask_top: cover property (mode == tx_power_pkg::MODE_ASK && idx_r == 3'h7);
  c_low_osc: cover property (low_osc_pick_o);
endmodule : tx_power_ramp_and_channel_word

// file: tb/amp_synth_model.sv
// Behavioural model of the analog amplifier and synthesizer oscillator pair
`timescale 1ns/10ps
module amp_synth_model (
  input  wire logic       clk_sys_i,
  input  wire logic [6:0] amp_level_i,
  input  wire logic       amp_hiz_i,
  input  wire logic       low_osc_pick_i,
  input  wire logic       high_osc_pick_i,
  output logic            drive_o,
  output logic            osc_err_o
);
  // Stage drives only with a nonzero code and high impedance released
  always_ff @(posedge clk_sys_i) begin
    drive_o <= !amp_hiz_i && (amp_level_i != 7'h00);
  end

  // Exactly one oscillator may run at a time
  always_ff @(posedge clk_sys_i) begin
    osc_err_o <= (low_osc_pick_i == high_osc_pick_i);
  end
endmodule : amp_synth_model

// file: tb/test_tx_power_ramp_and_channel_word.sv
// Self-checking testbench of the transmit control block
`timescale 1ns/10ps
`include "tx_power_regs.svh"
module test_tx_power_ramp_and_channel_word;
  logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, d;
  logic tx_active_i = 1'b0, tx_bit_i = 1'b0, amp_hiz_o, low_osc_pick_o, high_osc_pick_o;
  logic [6:0] amp_level_o;
  logic [1:0] amp_load_tune_o;
  logic [31:0] centre_hz_o;
  logic drive, osc_err;
  int n_errors = 0, check_count = 0, n;

  always #5 clk_sys_i = ~clk_sys_i;

  tx_power_ramp_and_channel_word uut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .tx_active_i(tx_active_i),
    .tx_bit_i(tx_bit_i), .amp_level_o(amp_level_o), .amp_hiz_o(amp_hiz_o),
    .amp_load_tune_o(amp_load_tune_o), .centre_hz_o(centre_hz_o),
    .low_osc_pick_o(low_osc_pick_o), .high_osc_pick_o(high_osc_pick_o));
  amp_synth_model far (.clk_sys_i(clk_sys_i), .amp_level_i(amp_level_o), .amp_hiz_i(amp_hiz_o),
    .low_osc_pick_i(low_osc_pick_o), .high_osc_pick_i(high_osc_pick_o),
    .drive_o(drive), .osc_err_o(osc_err));

  task print_verdict;
    if (n_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= v;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1; reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask : rd

  // Bounded wait; n returns the cycles spent
  task wait_lvl(input logic [6:0] e, output int c);
    c = 0;
    while (amp_level_o !== e && c < 500) begin
      @(posedge clk_sys_i); #1 c++;
    end
    if (c >= 500) begin
      n_errors++;
      print_verdict();
    end
  endtask : wait_lvl

  task sc_reset;
    chk({amp_level_o, amp_hiz_o, high_osc_pick_o}, {7'h00, 1'b1, 1'b1});
    rd(`OFS_RAMP_CFG, d); chk(d, `RAMP_CFG_RST);
    rd(8'h40, d); chk(d, 8'h00);
  endtask : sc_reset

  // Ramp 10,20,reserved code; hold 3 with tick every 2 cycles gives 8-cycle steps
  task sc_fm_ramp;
    wr(`OFS_EIGHTH_LO, 8'h01); wr(`OFS_EIGHTH_HI, 8'h00);
    wr(8'h00, 8'h0A); wr(8'h01, 8'h14); wr(8'h02, 8'h7F);
    rd(8'h02, d); chk(d, 8'h7F);
    wr(`OFS_MODE, 8'h00); wr(`OFS_RAMP_CFG, 8'h35);
    tx_active_i <= 1'b1;
    wait_lvl(7'h0A, n); wait_lvl(7'h14, n); wait_lvl(7'h5A, n);
    chk(n, 8);
    #20 chk({drive, amp_hiz_o}, 2'b10);
    tx_active_i <= 1'b0;
    wait_lvl(7'h14, n); wait_lvl(7'h0A, n); chk(n, 8);
    wait_lvl(7'h00, n); @(posedge clk_sys_i); #1 chk(amp_hiz_o, 1'b1);
  endtask : sc_fm_ramp

  task sc_ask_ook;
    for (int i = 0; i < 8; i++) wr(8'(i), 8'(i * 10 + 5));
    wr(`OFS_MODE, 8'h01); wr(`OFS_RAMP_CFG, 8'hCE);
    // Load tune output lags the register by one cycle
    @(posedge clk_sys_i);
    #1 chk(amp_load_tune_o, 2'h3);
    tx_bit_i <= 1'b1; tx_active_i <= 1'b1;
    wait_lvl(7'd75, n); repeat (20) @(posedge clk_sys_i);
    #1 chk(amp_level_o, 7'd75);
    tx_bit_i <= 1'b0; wait_lvl(7'd65, n); wait_lvl(7'd55, n);
    chk(n, 2);
    wait_lvl(7'd5, n); repeat (20) @(posedge clk_sys_i);
    #1 chk(amp_level_o, 7'd5);
    wr(`OFS_MODE, 8'h02); tx_bit_i <= 1'b1;
    wait_lvl(7'd75, n); chk(n <= 3, 1'b1);
    tx_bit_i <= 1'b0; wait_lvl(7'd5, n); chk(n <= 3, 1'b1);
    tx_active_i <= 1'b0; wait_lvl(7'h00, n);
    // FM without ramping jumps straight to the top entry and back to off
    wr(`OFS_MODE, 8'h00); tx_active_i <= 1'b1;
    wait_lvl(7'd75, n); chk(n <= 3, 1'b1);
    tx_active_i <= 1'b0; wait_lvl(7'h00, n); chk(n <= 3, 1'b1);
  endtask : sc_ask_ook

  // Base word bytes, band/halve setting, expected centre and low pick
  task sc_freq;
    logic [7:0] b2 [4] = '{8'h04, 8'h1C, 8'h1C, 8'h1C};
    logic [7:0] rb [4] = '{8'h00, 8'h00, 8'h01, 8'h02};
    logic [31:0] ex [4] = '{32'd26001486, 32'd182001486, 32'd91001486, 32'd45501486};
    logic lo [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    wr(`OFS_TRIM_LO, 8'hFF); wr(`OFS_TRIM_HI, 8'h0F);
    wr(`OFS_RASTER, 8'h01); wr(`OFS_CHAN, 8'h02);
    // Band 1 divides by four so a band mix-up shows in the centre
    wr(`OFS_BANDF_BASE + 8'h01, 8'h04);
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_BASE_B2, b2[i]); wr(`OFS_REF_BAND, rb[i]);
      n = 0;
      while (centre_hz_o !== ex[i] && n < 300) begin
        @(posedge clk_sys_i); #1 n++;
      end
      chk(centre_hz_o, ex[i]);
      chk({low_osc_pick_o, high_osc_pick_o, osc_err}, {lo[i], ~lo[i], 1'b0});
    end
  endtask : sc_freq

  initial begin
    repeat (8) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i); #1;
    sc_reset();
    sc_fm_ramp();
    sc_ask_ook();
    sc_freq();
    print_verdict();
  end
endmodule : test_tx_power_ramp_and_channel_word
